// ### common/mre_pkg.sv
// Package with constants, encodings and carriers for the execute block.
`default_nettype none
package mre_pkg;

  // ****************************************************************
  // Instruction word and operand layout
  // ****************************************************************
  localparam int unsigned INSTR_W = 14; // Width of one program word.
  localparam int unsigned DATA_W = 8; // Width of accumulator and files.
  localparam int unsigned FADDR_W = 7; // File address, 0 to 127.
  localparam int unsigned PC_W = 13; // Width of a return address.
  localparam int unsigned DEST_BIT = 7; // Position of the destination bit.

  // Opcode match values; the literal forms compare the top four bits,
  // the file forms the top six, the store form the top seven.
  localparam logic [3:0] OPC_LIT_LOAD = 4'hc;
  localparam logic [3:0] OPC_RET_LIT = 4'hd;
  localparam logic [5:0] OPC_OR_FILE = 6'h04;
  localparam logic [5:0] OPC_MOVE_FILE = 6'h08;
  localparam logic [5:0] OPC_ROT_LEFT = 6'h0d;
  localparam logic [5:0] OPC_ROT_RIGHT = 6'h0c;
  localparam logic [6:0] OPC_STORE_ACC = 7'h01;
  localparam logic [13:0] OPC_INT_RETURN = 14'h0009;
  localparam logic [13:0] OPC_NOP_MASK = 14'h3f9f; // Don't-care bits clear.
  localparam logic [13:0] OPC_NOP_VALUE = 14'h0000;

  // ****************************************************************
  // Register map on the APB side, byte addresses
  // ****************************************************************
  localparam logic [11:0] ADDR_CTRL = 12'h000; // Run enable.
  localparam logic [11:0] ADDR_ACCUM = 12'h004; // Working accumulator.
  localparam logic [11:0] ADDR_STATUS = 12'h008; // Carry and zero flags.
  localparam logic [11:0] ADDR_INTCTL = 12'h00c; // Interrupt enable.
  localparam logic [11:0] ADDR_DIAG = 12'h010; // Sticky error and state.

  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam int unsigned STATUS_C_BIT = 0;
  localparam int unsigned STATUS_Z_BIT = 2;
  localparam int unsigned INTCTL_GIE_BIT = 7;
  localparam int unsigned DIAG_ILLEGAL_BIT = 0;
  localparam int unsigned DIAG_STATE_LSB = 8;

  // Values after reset.
  localparam logic RST_RUN = 1'b1;
  localparam logic [7:0] RST_ACCUM = 8'h00;
  localparam logic RST_FLAG = 1'b0;
  localparam logic RST_GIE = 1'b0;

  // ****************************************************************
  // Types
  // ****************************************************************
  // Decoded operation.
  typedef enum logic [3:0] {
    OP_NOP, OP_LIT_LOAD, OP_OR_FILE, OP_STORE_ACC, OP_MOVE_FILE,
    OP_ROT_LEFT, OP_ROT_RIGHT, OP_RET_LIT, OP_INT_RETURN, OP_ILLEGAL
  } mre_op_t;

  // Sequencer states, Gray coded around the ring.
  typedef enum logic [1:0] {
    ST_FETCH = 2'b00,
    ST_EXEC = 2'b01,
    ST_FLUSH_A = 2'b11,
    ST_FLUSH_B = 2'b10
  } mre_state_t;

  // Decoded instruction fields.
  typedef struct packed {
    mre_op_t op;
    logic dest;
    logic [6:0] faddr;
    logic [7:0] lit;
  } mre_dec_t;

  // One write toward the file register array.
  typedef struct packed {
    logic en;
    logic [6:0] addr;
    logic [7:0] data;
  } mre_fwr_t;

  // Program counter redirect toward fetch.
  typedef struct packed {
    logic load;
    logic [12:0] addr;
  } mre_pcld_t;

endpackage
`default_nettype wire

// ### rtl/mre_decode.sv
// Instruction decoder for the execute block.
`timescale 1ns/1ps
`default_nettype none
module mre_decode
(
  input wire logic [mre_pkg::INSTR_W-1:0] instr_word,
  output mre_pkg::mre_dec_t dec
);
  import mre_pkg::*;

  // ****************************************************************
  // Classify the word and pull out its operand fields
  // ****************************************************************
  // Operand fields are taken for every word; only the op decides
  // which of them the execute stage looks at.
  always_comb
  begin
    dec.dest = instr_word[DEST_BIT];
    dec.faddr = instr_word[FADDR_W-1:0];
    dec.lit = instr_word[DATA_W-1:0];
    if (instr_word[13:10] == OPC_LIT_LOAD)
      dec.op = OP_LIT_LOAD;
    else if (instr_word[13:10] == OPC_RET_LIT)
      dec.op = OP_RET_LIT;
    else if (instr_word[13:8] == OPC_OR_FILE)
      dec.op = OP_OR_FILE;
    else if (instr_word[13:8] == OPC_MOVE_FILE)
      dec.op = OP_MOVE_FILE;
    else if (instr_word[13:8] == OPC_ROT_LEFT)
      dec.op = OP_ROT_LEFT;
    else if (instr_word[13:8] == OPC_ROT_RIGHT)
      dec.op = OP_ROT_RIGHT;
    else if (instr_word[13:7] == OPC_STORE_ACC)
      dec.op = OP_STORE_ACC;
    else if (instr_word == OPC_INT_RETURN)
      dec.op = OP_INT_RETURN;
    else if ((instr_word & OPC_NOP_MASK) == OPC_NOP_VALUE)
      dec.op = OP_NOP;
    else
      dec.op = OP_ILLEGAL; // Outside this block's instruction subset.
  end

endmodule
`default_nettype wire

// ### rtl/mre_alu.sv
// Data path for OR, move and the two rotates through carry.
`timescale 1ns/1ps
`default_nettype none
module mre_alu
(
  input wire mre_pkg::mre_op_t op,
  input wire logic [mre_pkg::DATA_W-1:0] accum,
  input wire logic [mre_pkg::DATA_W-1:0] fdata,
  input wire logic carry_in,
  output logic [mre_pkg::DATA_W-1:0] result,
  output logic carry_out,
  output logic zero
);
  import mre_pkg::*;

  // ****************************************************************
  // Result and flag candidates
  // ****************************************************************
  // The caller decides which flag it keeps; this stage only offers
  // both, so that no flag moves by accident here.
  always_comb
  begin
    result = fdata;
    carry_out = carry_in;
    unique case (op)
      OP_OR_FILE:
        result = accum | fdata;
      OP_ROT_LEFT:
      begin
        result = {fdata[6:0], carry_in};
        carry_out = fdata[7];
      end
      OP_ROT_RIGHT:
      begin
        result = {carry_in, fdata[7:1]};
        carry_out = fdata[0];
      end
      default:
        result = fdata; // Moves pass the file value through.
    endcase
    zero = (result == 8'h00);
  end

endmodule
`default_nettype wire

// ### rtl/mre_exec.sv
// Execute stage for loads, OR, moves, rotates and returns, with APB.
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module mre_exec
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic instr_valid,
  input wire logic [mre_pkg::INSTR_W-1:0] instr_word,
  output logic instr_ready,
  output logic [mre_pkg::FADDR_W-1:0] file_rd_addr,
  input wire logic [mre_pkg::DATA_W-1:0] file_rd_data,
  output mre_pkg::mre_fwr_t file_wr,
  input wire logic [mre_pkg::PC_W-1:0] top_of_return_stack,
  output logic stack_pop,
  output mre_pkg::mre_pcld_t pc_load,
  output logic fetch_flush,
  output logic global_interrupt_enable
);
  import mre_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  mre_state_t state_r, state_nxt; // Sequencer position.
  mre_dec_t dec_now; // Decode of the word on the port.
  mre_dec_t dec_r, dec_nxt; // Instruction held for execution.
  logic [7:0] accum_r, accum_nxt; // Working accumulator.
  logic carry_r, carry_nxt; // Carry flag.
  logic zero_r, zero_nxt; // Zero flag.
  logic gie_r, gie_nxt; // Global interrupt enable.
  logic run_r, run_nxt; // Software run enable.
  logic illegal_r, illegal_nxt; // Sticky unsupported-op flag.
  logic [6:0] rd_addr_r, rd_addr_nxt; // Registered file read address.
  mre_fwr_t fwr_r, fwr_nxt; // Registered file write.
  mre_pcld_t pcld_r, pcld_nxt; // Registered counter redirect.
  logic pop_r, pop_nxt; // Registered stack pop pulse.
  logic flush_r, flush_nxt; // Registered prefetch discard pulse.
  logic [31:0] prdata_r, prdata_nxt; // Read data held for the access.
  logic [7:0] alu_result; // Data path result.
  logic alu_carry; // Data path carry candidate.
  logic alu_zero; // Data path zero candidate.
  logic take; // Instruction accepted this cycle.
  logic bus_wr; // APB write takes effect at this edge.
  logic bus_setup; // APB setup cycle.
  logic addr_hit; // Address decodes to a register.

  // ****************************************************************
  // Submodules
  // ****************************************************************
  mre_decode u_decode
  (
    .instr_word(instr_word),
    .dec(dec_now)
  );

  mre_alu u_alu
  (
    .op(dec_r.op),
    .accum(accum_r),
    .fdata(file_rd_data),
    .carry_in(carry_r),
    .result(alu_result),
    .carry_out(alu_carry),
    .zero(alu_zero)
  );

  // ****************************************************************
  // Handshakes and port wiring
  // ****************************************************************
  // A word is taken only at the start of an instruction cycle, so a
  // stalled fetch simply waits; software can hold the core with run.
  assign take = instr_valid && instr_ready;
  assign instr_ready = (state_r == ST_FETCH) && run_r;
  assign file_rd_addr = rd_addr_r;
  assign file_wr = fwr_r;
  assign pc_load = pcld_r;
  assign stack_pop = pop_r;
  assign fetch_flush = flush_r;
  assign global_interrupt_enable = gie_r;

  // Zero-wait APB slave; unmapped addresses answer with an error.
  assign bus_setup = psel && !penable;
  assign bus_wr = psel && penable && pwrite;
  assign addr_hit = (paddr == ADDR_CTRL) || (paddr == ADDR_ACCUM) ||
                    (paddr == ADDR_STATUS) || (paddr == ADDR_INTCTL) ||
                    (paddr == ADDR_DIAG);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_hit;
  assign prdata = prdata_r;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // Each instruction cycle is two clocks: FETCH registers the file
  // address, EXEC presents it, sees the read data and commits. Returns
  // add the two FLUSH clocks, a second instruction cycle in which the
  // prefetched word is thrown away.
  always_comb
  begin
    state_nxt = state_r;
    dec_nxt = dec_r;
    rd_addr_nxt = rd_addr_r;
    unique case (state_r)
      ST_FETCH:
        if (take)
        begin
          dec_nxt = dec_now;
          rd_addr_nxt = dec_now.faddr;
          state_nxt = ST_EXEC;
        end
      ST_EXEC:
        if (dec_r.op == OP_RET_LIT || dec_r.op == OP_INT_RETURN)
          state_nxt = ST_FLUSH_A;
        else
          state_nxt = ST_FETCH;
      ST_FLUSH_A:
        state_nxt = ST_FLUSH_B;
      ST_FLUSH_B:
        state_nxt = ST_FETCH;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r <= ST_FETCH;
      dec_r <= '0;
      rd_addr_r <= 7'h00;
    end
    else
    begin
      state_r <= state_nxt;
      dec_r <= dec_nxt;
      rd_addr_r <= rd_addr_nxt;
    end
  end

  // ****************************************************************
  // Execution and architectural state
  // ****************************************************************
  // Software writes are applied first and the instruction's effect
  // overrides them, so a commit is never lost to a racing bus write.
  // The interrupt enable and the sticky error follow set-over-clear.
  always_comb
  begin
    accum_nxt = accum_r;
    carry_nxt = carry_r;
    zero_nxt = zero_r;
    gie_nxt = gie_r;
    run_nxt = run_r;
    illegal_nxt = illegal_r;
    fwr_nxt = '0;
    pcld_nxt = '0;
    pop_nxt = 1'b0;
    flush_nxt = 1'b0;
    if (bus_wr)
    begin
      unique case (paddr)
        ADDR_CTRL:
          run_nxt = pwdata[CTRL_RUN_BIT];
        ADDR_ACCUM:
          accum_nxt = pwdata[7:0];
        ADDR_STATUS:
        begin
          carry_nxt = pwdata[STATUS_C_BIT];
          zero_nxt = pwdata[STATUS_Z_BIT];
        end
        ADDR_INTCTL:
          gie_nxt = pwdata[INTCTL_GIE_BIT];
        ADDR_DIAG:
          if (pwdata[DIAG_ILLEGAL_BIT])
            illegal_nxt = 1'b0; // Write one to clear.
        default:
          run_nxt = run_r; // Unmapped: no state changes.
      endcase
    end
    if (state_r == ST_EXEC)
    begin
      unique case (dec_r.op)
        OP_LIT_LOAD:
          accum_nxt = dec_r.lit;
        OP_OR_FILE, OP_MOVE_FILE, OP_ROT_LEFT, OP_ROT_RIGHT:
        begin
          if (dec_r.op == OP_ROT_LEFT || dec_r.op == OP_ROT_RIGHT)
            carry_nxt = alu_carry;
          else
            zero_nxt = alu_zero;
          if (dec_r.dest)
          begin
            fwr_nxt.en = 1'b1;
            fwr_nxt.addr = dec_r.faddr;
            fwr_nxt.data = alu_result;
          end
          else
            accum_nxt = alu_result;
        end
        OP_STORE_ACC:
        begin
          fwr_nxt.en = 1'b1;
          fwr_nxt.addr = dec_r.faddr;
          fwr_nxt.data = accum_r;
        end
        OP_RET_LIT, OP_INT_RETURN:
        begin
          if (dec_r.op == OP_RET_LIT)
            accum_nxt = dec_r.lit;
          else
            gie_nxt = 1'b1;
          pop_nxt = 1'b1;
          pcld_nxt.load = 1'b1;
          pcld_nxt.addr = top_of_return_stack;
          flush_nxt = 1'b1;
        end
        OP_ILLEGAL:
          illegal_nxt = 1'b1; // Flagged for software, nothing else.
        OP_NOP:
          illegal_nxt = illegal_r;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      accum_r <= RST_ACCUM;
      carry_r <= RST_FLAG;
      zero_r <= RST_FLAG;
      gie_r <= RST_GIE;
      run_r <= RST_RUN;
      illegal_r <= 1'b0;
      fwr_r <= '0;
      pcld_r <= '0;
      pop_r <= 1'b0;
      flush_r <= 1'b0;
    end
    else
    begin
      accum_r <= accum_nxt;
      carry_r <= carry_nxt;
      zero_r <= zero_nxt;
      gie_r <= gie_nxt;
      run_r <= run_nxt;
      illegal_r <= illegal_nxt;
      fwr_r <= fwr_nxt;
      pcld_r <= pcld_nxt;
      pop_r <= pop_nxt;
      flush_r <= flush_nxt;
    end
  end

  // ****************************************************************
  // APB read data
  // ****************************************************************
  // Read data is captured in the setup cycle so that prdata comes
  // from a flop while the slave still answers with no wait state.
  // The value is therefore as of the setup edge, one clock early.
  always_comb
  begin
    prdata_nxt = prdata_r;
    if (bus_setup && !pwrite)
    begin
      prdata_nxt = 32'h0000_0000;
      unique case (paddr)
        ADDR_CTRL:
          prdata_nxt[CTRL_RUN_BIT] = run_r;
        ADDR_ACCUM:
          prdata_nxt[7:0] = accum_r;
        ADDR_STATUS:
        begin
          prdata_nxt[STATUS_C_BIT] = carry_r;
          prdata_nxt[STATUS_Z_BIT] = zero_r;
        end
        ADDR_INTCTL:
          prdata_nxt[INTCTL_GIE_BIT] = gie_r;
        ADDR_DIAG:
        begin
          prdata_nxt[DIAG_ILLEGAL_BIT] = illegal_r;
          prdata_nxt[DIAG_STATE_LSB +: 2] = state_r;
        end
        default:
          prdata_nxt = 32'h0000_0000; // Unmapped reads as zero.
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      prdata_r <= 32'h0000_0000;
    else
      prdata_r <= prdata_nxt;
  end

endmodule
`default_nettype wire

// ### sim/mre_exec_sva.sv
// Concurrent checks on the instruction side of the execute block.
`timescale 1ns/1ps
`default_nettype none
module mre_exec_sva
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic instr_valid,
  input wire logic [mre_pkg::INSTR_W-1:0] instr_word,
  input wire logic instr_ready,
  input wire logic [mre_pkg::DATA_W-1:0] file_rd_data,
  input wire mre_pkg::mre_fwr_t file_wr,
  input wire logic [mre_pkg::PC_W-1:0] top_of_return_stack,
  input wire logic stack_pop,
  input wire mre_pkg::mre_pcld_t pc_load,
  input wire logic fetch_flush,
  input wire logic global_interrupt_enable
);
  import mre_pkg::*;
  // An instruction is taken at this edge.
  logic take;
  assign take = instr_valid && instr_ready;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  // ****************************************************************
  // Named steps
  // ****************************************************************
  sequence s_lit;
    take && instr_word[13:10] == OPC_LIT_LOAD;
  endsequence
  sequence s_ret_lit;
    take && instr_word[13:10] == OPC_RET_LIT;
  endsequence
  sequence s_int_ret;
    take && instr_word == OPC_INT_RETURN;
  endsequence
  sequence s_nop;
    take && (instr_word & OPC_NOP_MASK) == OPC_NOP_VALUE;
  endsequence
  sequence s_store;
    take && instr_word[13:7] == OPC_STORE_ACC;
  endsequence
  sequence s_file;
    take && (instr_word[13:8] == OPC_OR_FILE
      || instr_word[13:8] == OPC_MOVE_FILE
      || instr_word[13:8] == OPC_ROT_LEFT
      || instr_word[13:8] == OPC_ROT_RIGHT);
  endsequence
  // Rotates that write back, so the result shows on the file port.
  sequence s_rl_wr;
    take && instr_word[13:8] == OPC_ROT_LEFT && instr_word[DEST_BIT];
  endsequence
  sequence s_rr_wr;
    take && instr_word[13:8] == OPC_ROT_RIGHT && instr_word[DEST_BIT];
  endsequence
  // The three redirect pulses always travel together.
  sequence s_redirect;
    stack_pop && pc_load.load && fetch_flush;
  endsequence
  // ****************************************************************
  // Assertions
  // ****************************************************************
  chk_lit_no_write: assert property (
    s_lit |-> ##2 !(file_wr.en || stack_pop))
    else $error("literal load touched file or stack");
  chk_store_write: assert property (
    s_store |-> ##2 file_wr.en && file_wr.addr == $past(instr_word[6:0], 2))
    else $error("store did not write the addressed file");
  chk_file_dest: assert property (
    s_file |-> ##2 file_wr.en == $past(instr_word[DEST_BIT], 2))
    else $error("destination bit not honoured");
  chk_rot_left: assert property (
    s_rl_wr |-> ##2 file_wr.data[7:1] == $past(file_rd_data[6:0]))
    else $error("left rotate data wrong");
  chk_rot_right: assert property (
    s_rr_wr |-> ##2 file_wr.data[6:0] == $past(file_rd_data[7:1]))
    else $error("right rotate data wrong");
  chk_ret_redirect: assert property (
    s_ret_lit |-> ##2 s_redirect)
    else $error("literal return did not pop and redirect");
  chk_ret_stall: assert property (
    s_ret_lit |=> !instr_ready [*3])
    else $error("literal return shorter than two instruction cycles");
  chk_pulse_pair: assert property (
    (stack_pop || pc_load.load || fetch_flush) |-> s_redirect)
    else $error("redirect pulses not aligned");
  chk_pc_from_tos: assert property (
    pc_load.load |-> pc_load.addr == $past(top_of_return_stack))
    else $error("counter not loaded from stack top");
  chk_int_ret_gie: assert property (
    s_int_ret |-> ##2 (global_interrupt_enable and s_redirect))
    else $error("interrupt return missed enable or pop");
  chk_nop_quiet: assert property (
    s_nop |-> ##2 !(file_wr.en || stack_pop || pc_load.load))
    else $error("no-operation had a side effect");
endmodule
bind mre_exec mre_exec_sva u_sva (.clk_sys(clk_sys), .rstn(rstn),
  .instr_valid(instr_valid), .instr_word(instr_word),
  .instr_ready(instr_ready), .file_rd_data(file_rd_data),
  .file_wr(file_wr), .top_of_return_stack(top_of_return_stack),
  .stack_pop(stack_pop), .pc_load(pc_load), .fetch_flush(fetch_flush),
  .global_interrupt_enable(global_interrupt_enable));
`default_nettype wire

// ### sim/mre_exec_test.sv
// Self-checking testbench for the execute block.
`timescale 1ns/1ps
`default_nettype none
module mre_exec_test;
  import mre_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic instr_valid = 1'b0;
  logic [13:0] instr_word = 14'h0000;
  logic instr_ready;
  logic [6:0] file_rd_addr;
  logic [7:0] file_rd_data;
  mre_fwr_t file_wr;
  logic [12:0] top_of_return_stack = 13'h0000;
  logic stack_pop;
  mre_pcld_t pc_load;
  logic fetch_flush;
  logic global_interrupt_enable;
  logic [7:0] mem [0:127]; // Behavioural file register array.
  logic [31:0] rq; // Last APB read data.
  logic re; // Last APB error flag.
  logic [12:0] last_pc = 13'h0000; // Last redirect target seen.
  int n_pop = 0;
  int n_mismatch = 0;
  int n_tests = 0;
  int low; // Cycles with instr_ready low after a take.
  always #12.5 clk_sys = ~clk_sys;
  mre_exec uut (.clk_sys(clk_sys), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_ready(instr_ready), .file_rd_addr(file_rd_addr),
    .file_rd_data(file_rd_data), .file_wr(file_wr),
    .top_of_return_stack(top_of_return_stack), .stack_pop(stack_pop),
    .pc_load(pc_load), .fetch_flush(fetch_flush),
    .global_interrupt_enable(global_interrupt_enable));
  // The file answers combinationally, as the block expects.
  assign file_rd_data = mem[file_rd_addr];
  // Writes land at the edge, like a real register file.
  always @(posedge clk_sys)
  begin
    if (file_wr.en === 1'b1)
      mem[file_wr.addr] <= file_wr.data;
  end
  // Pulses stand one whole cycle, so the falling edge sees each once.
  always @(negedge clk_sys)
  begin
    if (stack_pop === 1'b1)
      n_pop++;
    if (pc_load.load === 1'b1)
      last_pc = pc_load.addr;
  end
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  // One APB transfer; waits for pready rather than assuming a count.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Offer one word, wait for the take, then count the stall.
  task automatic exe(input logic [13:0] w);
    int k;
    k = 0;
    @(posedge clk_sys);
    instr_valid <= 1'b1;
    instr_word <= w;
    @(negedge clk_sys);
    while (instr_ready !== 1'b1 && k < 50)
    begin
      @(negedge clk_sys);
      k++;
    end
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    low = 0;
    @(negedge clk_sys);
    while (instr_ready !== 1'b1 && low < 50)
    begin
      low++;
      @(negedge clk_sys);
    end
    // The file write shows one clock after the commit and lands at the
    // edge after that, so wait past it before anyone looks at the file.
    @(negedge clk_sys);
  endtask
  task automatic acc(input logic [7:0] e);
    apb(1'b0, ADDR_ACCUM, 32'h0);
    chk("accum", {24'h0, e}, {24'h0, rq[7:0]});
  endtask
  // Expected flags given as {zero, carry}.
  task automatic sts(input logic [1:0] e);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("flags", {30'h0, e}, {30'h0, rq[STATUS_Z_BIT], rq[STATUS_C_BIT]});
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    acc(RST_ACCUM);
    sts(2'b00);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, re});
    $display("reset values done");
  endtask
  task automatic t_load_store;
    exe({4'hc, 2'b00, 8'h00});
    chk("load stall", 32'h1, 32'(low));
    sts(2'b00);
    exe({4'hc, 2'b00, 8'hff});
    acc(8'hff);
    apb(1'b1, ADDR_STATUS, 32'h5);
    exe({7'h01, 7'h7f});
    chk("store file", 32'hff, {24'h0, mem[127]});
    sts(2'b11);
    $display("load and store done");
  endtask
  task automatic t_or;
    mem[5] = 8'h0f;
    mem[6] = 8'h81;
    exe({4'hc, 2'b00, 8'h30});
    exe({6'h04, 1'b0, 7'h05});
    acc(8'h3f);
    chk("or keeps file", 32'h0f, {24'h0, mem[5]});
    sts(2'b01);
    exe({4'hc, 2'b00, 8'h42});
    exe({6'h04, 1'b1, 7'h06});
    chk("or file", 32'hc3, {24'h0, mem[6]});
    acc(8'h42);
    $display("or done");
  endtask
  task automatic t_move;
    mem[16] = 8'h00;
    exe({6'h08, 1'b1, 7'h10});
    chk("move self", 32'h0, {24'h0, mem[16]});
    sts(2'b11);
    exe({6'h08, 1'b1, 7'h7f});
    sts(2'b01);
    exe({6'h08, 1'b0, 7'h10});
    acc(8'h00);
    sts(2'b11);
    $display("move done");
  endtask
  task automatic t_rot;
    mem[9] = 8'h80;
    apb(1'b1, ADDR_STATUS, 32'h5);
    exe({6'h0d, 1'b0, 7'h09});
    acc(8'h01);
    sts(2'b11);
    chk("rotl keeps file", 32'h80, {24'h0, mem[9]});
    exe({6'h0c, 1'b1, 7'h09});
    chk("rotr file", 32'hc0, {24'h0, mem[9]});
    sts(2'b10);
    exe({6'h0d, 1'b1, 7'h09});
    chk("rotl file", 32'h80, {24'h0, mem[9]});
    exe({6'h0c, 1'b0, 7'h09});
    acc(8'hc0);
    $display("rotates done");
  endtask
  task automatic t_ret;
    int p;
    p = n_pop;
    top_of_return_stack <= 13'h1abc;
    exe({4'hd, 2'b00, 8'h5a});
    chk("return stall", 32'h3, 32'(low));
    acc(8'h5a);
    sts(2'b10);
    chk("pop count", 32'(p + 1), 32'(n_pop));
    chk("return target", 32'h1abc, {19'h0, last_pc});
    top_of_return_stack <= 13'h0123;
    exe(14'h0009);
    chk("irq return stall", 32'h3, 32'(low));
    chk("irq return target", 32'h0123, {19'h0, last_pc});
    apb(1'b0, ADDR_INTCTL, 32'h0);
    chk("enable", 32'h1, {31'h0, rq[INTCTL_GIE_BIT]});
    sts(2'b10);
    $display("returns done");
  endtask
  task automatic t_nop;
    int p;
    p = n_pop;
    exe(14'h0000);
    chk("nop stall", 32'h1, 32'(low));
    acc(8'h5a);
    sts(2'b10);
    chk("nop pop", 32'(p), 32'(n_pop));
    $display("no-operation done");
  endtask
  // An unsupported word only raises the sticky flag; run low holds fetch.
  task automatic t_diag;
    exe(14'h3fff);
    acc(8'h5a);
    apb(1'b0, ADDR_DIAG, 32'h0);
    chk("illegal flag", 32'h1, rq);
    apb(1'b1, ADDR_DIAG, 32'h1);
    apb(1'b0, ADDR_DIAG, 32'h0);
    chk("illegal clear", 32'h0, rq);
    apb(1'b1, ADDR_CTRL, 32'h0);
    @(negedge clk_sys);
    chk("halted ready", 32'h0, {31'h0, instr_ready});
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("run bit", 32'h0, rq);
    apb(1'b1, ADDR_CTRL, 32'h1);
    $display("diagnostics done");
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Main sequence: reset for ten cycles, then each scenario.
  initial
  begin
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    t_reset();
    t_load_store();
    t_or();
    t_move();
    t_rot();
    t_ret();
    t_nop();
    t_diag();
    test_done();
  end
  // The whole run needs well under two thousand cycles.
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    $display("watchdog expired");
    test_done();
  end
endmodule
`default_nettype wire
